//--- se3_core.sv
// holds the instruction decoder and control of the three-wire serial eeprom core
// assumes the host drives select, serial clock and data in per the link timing, and
// that the serial clock is unrelated to sys_clk and may stand still between frames
// array read port and captured command cross as static data: they stand still
// whenever the other side looks, so reads during a busy cycle are unsupported

`timescale 1ns/1ps
`default_nettype none

module se3_core
  import se3_pkg::*;
#(
  parameter int PROG_CYCLES = PROG_CYCLES_DEF
) (
  input wire logic sys_clk, // system clock, 50 mhz
  input wire logic rst_b, // async reset, active low
  input wire logic chip_select, // select pin, active high
  input wire logic serial_clock_in, // link clock from host
  input wire logic serial_data_in, // serial data from host
  input wire logic width_select, // high words, low bytes
  output logic data_out, // serial data out level
  output logic data_out_oe, // data out driven when high
  output logic prog_busy, // self-timed cycle running
  output logic write_enabled // write enable latch
);

  // width of the programming timer
  localparam int PW = $clog2(PROG_CYCLES + 1);

  // ****************************************
  // link domain, clocked by serial_clock_in
  // ****************************************

  // strap copy and frame flag
  logic org_l1;
  logic org_l2;
  logic in_frame;
  se3_link_ph_t ph;
  se3_link_ph_t next_ph;
  // instruction capture
  logic [CNT_W-1:0] cnt;
  logic [SH_W-1:0] sh;
  logic [1:0] hdr_op;
  logic [1:0] hdr_sub;
  logic [ADDR_W-1:0] hdr_addr;
  logic frame_tog;
  // read streaming
  logic rd_oe;
  logic rd_bit;
  logic [IDX_W-1:0] rd_idx;
  logic [ADDR_W-1:0] rd_addr;
  logic [WORD_W-1:0] rd_data;

  // frame reset follows select so a read stops the moment select drops
  wire frm_rst_b = rst_b & chip_select;

  // strap synchroniser on the link clock
  always_ff @(posedge serial_clock_in or negedge rst_b) begin
    if (!rst_b) begin
      org_l1 <= ORG_RESET;
      org_l2 <= ORG_RESET;
    end else begin
      org_l1 <= width_select;
      org_l2 <= org_l1;
    end
  end

  // marks that the current frame has seen its first clock edge
  always_ff @(posedge serial_clock_in or negedge frm_rst_b) begin
    if (!frm_rst_b) begin
      in_frame <= 1'b0;
    end else begin
      in_frame <= 1'b1;
    end
  end

  // shift decode
  wire [SH_W-1:0] next_sh = {sh[SH_W-2:0], serial_data_in};
  wire [CNT_W-1:0] cnt_inc = (cnt == CNT_MAX) ? cnt : cnt + 5'h01;
  wire [CNT_W-1:0] hdr_len_l = org_l2 ? HDR_BITS_X16 : HDR_BITS_X8;
  // header complete on the edge that brings its last bit
  wire hdr_hit = in_frame & (ph == LP_SHIFT) & (cnt_inc == hdr_len_l);
  wire [1:0] new_op = org_l2 ? next_sh[OP_LSB_X16 +: 2] : next_sh[OP_LSB_X8 +: 2];
  wire [1:0] new_sub = org_l2 ? next_sh[SUB_LSB_X16 +: 2] : next_sh[SUB_LSB_X8 +: 2];
  wire [ADDR_W-1:0] new_addr = org_l2 ? {1'b0, next_sh[ADDR_BITS_X16-1:0]} : next_sh[ADDR_W-1:0];
  // a read turns the line round on that same edge
  wire rd_start = hdr_hit & (new_op == OP_READ);

  // link phase: hunt for start bit, shift, then stream read data
  always_comb begin
    next_ph = ph;
    if (!in_frame) begin
      next_ph = serial_data_in ? LP_SHIFT : LP_HUNT;
    end else begin
      case (ph)
        LP_HUNT: begin
          next_ph = serial_data_in ? LP_SHIFT : LP_HUNT;
        end
        LP_SHIFT: begin
          next_ph = rd_start ? LP_READ : LP_SHIFT;
        end
        LP_READ: begin
          next_ph = LP_READ;
        end
        default: begin
          next_ph = LP_HUNT;
        end
      endcase
    end
  end

  // bits after the start bit are counted and shifted
  wire shifting = in_frame & (ph != LP_HUNT);

  // command capture; held with no clock, so the sys side reads it after select falls
  always_ff @(posedge serial_clock_in or negedge rst_b) begin
    if (!rst_b) begin
      ph <= LP_HUNT;
      cnt <= '0;
      sh <= '0;
      frame_tog <= 1'b0;
    end else if (chip_select) begin
      ph <= next_ph;
      cnt <= shifting ? cnt_inc : '0;
      sh <= shifting ? next_sh : '0;
      frame_tog <= in_frame ? frame_tog : ~frame_tog;
    end
  end

  // header fields latched once the address is complete
  always_ff @(posedge serial_clock_in or negedge rst_b) begin
    if (!rst_b) begin
      hdr_op <= OP_READ;
      hdr_sub <= PROGRAM_LOCK_INSTR;
      hdr_addr <= '0;
    end else if (chip_select & hdr_hit) begin
      hdr_op <= new_op;
      hdr_sub <= new_sub;
      hdr_addr <= new_addr;
    end
  end

  // read streaming selection
  wire [IDX_W-1:0] top_idx = org_l2 ? TOP_IDX_X16 : TOP_IDX_X8;
  wire rd_last = (rd_idx == '0);
  wire [ADDR_BITS_X16-1:0] rd_addr_w = rd_addr[ADDR_BITS_X16-1:0] + 7'h01;
  wire [ADDR_W-1:0] rd_addr_inc = org_l2 ? {1'b0, rd_addr_w} : rd_addr + 8'h01;
  // stream steps on every edge after the dummy bit
  wire rd_step = in_frame & (ph == LP_READ);

  // read output shifter; loads on the read start edge, then steps on every rising link edge after it
  always_ff @(posedge serial_clock_in or negedge frm_rst_b) begin
    if (!frm_rst_b) begin
      rd_oe <= 1'b0;
      rd_bit <= 1'b0;
      rd_idx <= '0;
      rd_addr <= '0;
    end else if (rd_start) begin
      rd_oe <= 1'b1;
      rd_bit <= 1'b0;
      rd_idx <= top_idx;
      rd_addr <= new_addr;
    end else if (rd_step) begin
      rd_bit <= rd_data[rd_idx];
      rd_idx <= rd_last ? top_idx : rd_idx - 4'h1;
      rd_addr <= rd_last ? rd_addr_inc : rd_addr;
    end
  end

  // ****************************************
  // system domain, clocked by sys_clk
  // ****************************************

  // synchronised pins
  logic cs_s1;
  logic cs_s2;
  logic cs_d;
  logic org_s1;
  logic org_s2;
  logic tog_seen;
  // sequencer and timer
  se3_prog_st_t st;
  se3_prog_st_t next_st;
  logic [PW-1:0] prog_cnt;
  // job latched at a start
  logic [ADDR_W-1:0] job_addr;
  logic [WORD_W-1:0] job_data;
  logic job_all;
  logic job_word;
  // status reporting
  logic armed;
  logic [IDX_W-1:0] wait_cnt;
  logic status_oe;
  logic status_rdy;

  // select and strap synchronisers
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      cs_s1 <= 1'b0;
      cs_s2 <= 1'b0;
      cs_d <= 1'b0;
      org_s1 <= ORG_RESET;
      org_s2 <= ORG_RESET;
    end else begin
      cs_s1 <= chip_select;
      cs_s2 <= cs_s1;
      cs_d <= cs_s2;
      org_s1 <= width_select;
      org_s2 <= org_s1;
    end
  end

  // decode at the select fall; link fields stand still since the last link edge
  wire cs_fall = cs_d & ~cs_s2;
  // a frame with no clock edges leaves the toggle alone and decodes nothing
  wire fresh = (frame_tog != tog_seen);
  wire [CNT_W-1:0] hdr_len_s = org_s2 ? HDR_BITS_X16 : HDR_BITS_X8;
  wire [CNT_W-1:0] dat_len_s = org_s2 ? DATA_BITS_X16 : DATA_BITS_X8;
  // instruction class
  wire op_special = (hdr_op == OP_SPECIAL);
  wire op_fill = op_special & (hdr_sub == FILL_ARRAY_INSTR);
  wire op_clear = op_special & (hdr_sub == CLEAR_ARRAY_INSTR);
  wire has_data = (hdr_op == OP_WRITE) | op_fill;
  // exact bit count after the start bit
  wire [CNT_W-1:0] need_len = has_data ? hdr_len_s + dat_len_s : hdr_len_s;
  wire idle = (st == SP_IDLE);
  // accepted only when idle, so a command while busy is dropped
  wire cmd_ok = cs_fall & fresh & idle & (hdr_op != OP_READ) & (cnt == need_len);
  // latch commands act without write enable
  wire is_lock = cmd_ok & op_special & (hdr_sub == PROGRAM_LOCK_INSTR);
  wire is_enable = cmd_ok & op_special & (hdr_sub == WRITE_ENABLE_INSTR);
  wire prog_op = (hdr_op == OP_WRITE) | (hdr_op == OP_ERASE) | op_fill | op_clear;
  wire start = cmd_ok & prog_op & write_enabled;
  // job contents from the last data bits shifted in
  wire [WORD_W-1:0] data_field = org_s2 ? sh[WORD_W-1:0] : {8'h00, sh[BYTE_W-1:0]};
  wire [WORD_W-1:0] next_job_data = has_data ? data_field : ERASED_WORD;
  wire prog_done = (st == SP_PROG) & (prog_cnt == '0);
  // timer loads at a start and runs down only while programming
  wire [PW-1:0] next_prog_cnt = start ? PW'(PROG_CYCLES - 1) :
    (((st == SP_PROG) & ~prog_done) ? prog_cnt - 1'b1 : prog_cnt);

  // program sequencer
  always_comb begin
    next_st = st;
    case (st)
      SP_IDLE: begin
        next_st = start ? SP_PROG : SP_IDLE;
      end
      SP_PROG: begin
        next_st = prog_done ? SP_IDLE : SP_PROG;
      end
      default: begin
        next_st = SP_IDLE;
      end
    endcase
  end

  // state, timer and frame bookkeeping
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      st <= SP_IDLE;
      prog_busy <= 1'b0;
      prog_cnt <= '0;
      tog_seen <= 1'b0;
    end else begin
      st <= next_st;
      prog_busy <= (next_st == SP_PROG);
      prog_cnt <= next_prog_cnt;
      tog_seen <= cs_fall ? frame_tog : tog_seen;
    end
  end

  // write enable latch; clear only by disable instruction or reset
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      write_enabled <= WEL_RESET;
    end else if (is_enable) begin
      write_enabled <= 1'b1;
    end else if (is_lock) begin
      write_enabled <= 1'b0;
    end
  end

  // job latched at the start of a self-timed cycle
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      job_addr <= '0;
      job_data <= ERASED_WORD;
      job_all <= 1'b0;
      job_word <= ORG_RESET;
    end else if (start) begin
      job_addr <= hdr_addr;
      job_data <= next_job_data;
      job_all <= op_special;
      job_word <= org_s2;
    end
  end

  // status reporting; armed by a start, ends with the next fall or an unseen finish
  wire end_unseen = prog_done & ~cs_s2;
  wire next_armed = start | (armed & ~cs_fall & ~end_unseen);
  // status waits out the settle time after a start
  wire wait_done = (wait_cnt == '0);

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      armed <= 1'b0;
      wait_cnt <= '0;
      status_oe <= 1'b0;
      status_rdy <= 1'b0;
    end else begin
      armed <= next_armed;
      wait_cnt <= start ? STATUS_WAIT_LOAD : (wait_done ? wait_cnt : wait_cnt - 4'h1);
      status_oe <= next_armed & cs_s2 & wait_done & ~start;
      status_rdy <= (next_st == SP_IDLE);
    end
  end

  // ****************************************
  // array and pin drive
  // ****************************************

  // read port is looked at from the link side; the array only moves while busy
  se3_array u_array (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .wr_en(prog_done),
    .wr_all(job_all),
    .wr_word(job_word),
    .wr_addr(job_addr),
    .wr_data(job_data),
    .rd_word(org_l2),
    .rd_addr(rd_addr),
    .rd_data(rd_data)
  );

  // read data wins; otherwise status; floats when neither is presented
  assign data_out = rd_oe ? rd_bit : status_rdy;
  assign data_out_oe = rd_oe | status_oe;

endmodule : se3_core

`default_nettype wire

//--- se3_array.sv
// holds the shared constants, types and the byte-wide storage array of the serial eeprom core
// assumes a single system clock with an active-low asynchronous reset; the read port is
// combinational and is read from the serial clock domain while the array stands still

// ****************************************
// shared constants and types
// ****************************************
package se3_pkg;
  localparam int BYTE_W = 8;
  localparam int WORD_W = 16;
  localparam int ADDR_W = 8;
  localparam int NUM_BYTES = 256;
  localparam int SH_W = 26;
  localparam int CNT_W = 5;
  localparam int IDX_W = 4;
  localparam int ADDR_BITS_X16 = 7;
  // opcode after the start bit
  localparam logic [1:0] OP_SPECIAL = 2'h0;
  localparam logic [1:0] OP_WRITE = 2'h1;
  localparam logic [1:0] OP_READ = 2'h2;
  localparam logic [1:0] OP_ERASE = 2'h3;
  // special sub-codes in the two top address bits
  localparam logic [1:0] PROGRAM_LOCK_INSTR = 2'h0;
  localparam logic [1:0] FILL_ARRAY_INSTR = 2'h1;
  localparam logic [1:0] CLEAR_ARRAY_INSTR = 2'h2;
  localparam logic [1:0] WRITE_ENABLE_INSTR = 2'h3;
  // bits after the start bit
  localparam logic [CNT_W-1:0] HDR_BITS_X8 = 5'h0b;
  localparam logic [CNT_W-1:0] HDR_BITS_X16 = 5'h0a;
  localparam logic [CNT_W-1:0] DATA_BITS_X8 = 5'h08;
  localparam logic [CNT_W-1:0] DATA_BITS_X16 = 5'h10;
  localparam logic [CNT_W-1:0] CNT_MAX = 5'h1f;
  // field positions in the shift register once the header is in
  localparam int OP_LSB_X8 = 9;
  localparam int OP_LSB_X16 = 8;
  localparam int SUB_LSB_X8 = 7;
  localparam int SUB_LSB_X16 = 6;
  localparam logic [IDX_W-1:0] TOP_IDX_X8 = 4'h7;
  localparam logic [IDX_W-1:0] TOP_IDX_X16 = 4'hf;
  // reset values
  localparam logic [BYTE_W-1:0] ERASED_BYTE = 8'hff;
  localparam logic [WORD_W-1:0] ERASED_WORD = 16'hffff;
  localparam logic WEL_RESET = 1'h0;
  localparam logic ORG_RESET = 1'h1;
  // timing
  localparam int CLK_PERIOD_NS = 20;
  localparam int PROG_TIME_MS = 5;
  localparam int PROG_CYCLES_DEF = PROG_TIME_MS * 1000000 / CLK_PERIOD_NS;
  localparam int STATUS_WAIT_TIME_NS = 200;
  localparam int STATUS_WAIT_CYC = (STATUS_WAIT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [IDX_W-1:0] STATUS_WAIT_LOAD = IDX_W'(STATUS_WAIT_CYC);
  typedef enum logic [1:0] {
    LP_HUNT = 2'b00,
    LP_SHIFT = 2'b01,
    LP_READ = 2'b10
  } se3_link_ph_t;
  typedef enum logic {
    SP_IDLE = 1'b0,
    SP_PROG = 1'b1
  } se3_prog_st_t;
endpackage : se3_pkg

`timescale 1ns/1ps
`default_nettype none

// ****************************************
// storage array, 256 bytes of flip-flops
// ****************************************
module se3_array
  import se3_pkg::*;
(
  input wire logic sys_clk, // system clock
  input wire logic rst_b, // async reset, active low
  input wire logic wr_en, // one-cycle commit pulse
  input wire logic wr_all, // commit to every location
  input wire logic wr_word, // word organization for the commit
  input wire logic [ADDR_W-1:0] wr_addr, // byte or word address
  input wire logic [WORD_W-1:0] wr_data, // data, bytes in low half
  input wire logic rd_word, // word organization for the read
  input wire logic [ADDR_W-1:0] rd_addr, // byte or word address
  output logic [WORD_W-1:0] rd_data // read word, bytes in low half
);
  logic [BYTE_W-1:0] mem [NUM_BYTES];

  // one entry per byte; word n is byte 2n high and byte 2n+1 low
  genvar gi;
  generate
    for (gi = 0; gi < NUM_BYTES; gi++) begin : g_byte
      localparam logic [ADDR_W-1:0] IDX = ADDR_W'(gi);
      wire hit_word = (wr_addr[ADDR_W-2:0] == IDX[ADDR_W-1:1]);
      wire hit = wr_all | (wr_word ? hit_word : (wr_addr == IDX));
      wire [BYTE_W-1:0] val = (wr_word & ~IDX[0]) ? wr_data[WORD_W-1:BYTE_W] : wr_data[BYTE_W-1:0];
      // new value replaces the old, so no separate erase pass is needed
      always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
          mem[gi] <= ERASED_BYTE;
        end else if (wr_en & hit) begin
          mem[gi] <= val;
        end
      end
    end
  endgenerate

  // read selection
  wire [ADDR_W-1:0] rd_hi = {rd_addr[ADDR_W-2:0], 1'b0};
  wire [ADDR_W-1:0] rd_lo = {rd_addr[ADDR_W-2:0], 1'b1};
  assign rd_data = rd_word ? {mem[rd_hi], mem[rd_lo]} : {8'h00, mem[rd_addr]};
endmodule : se3_array

`default_nettype wire

//--- se3_core_asserts.sv
// concurrent checks of the serial eeprom core, seen from its ports only
// assumes it is bound onto se3_core and gets the same programming cycle count
`timescale 1ns/1ps
`default_nettype none

// ****************************************
// port checker
// ****************************************
module se3_core_asserts
  import se3_pkg::*;
#(
  parameter int PROG_CYCLES = PROG_CYCLES_DEF
) (
  input wire logic sys_clk, // system clock
  input wire logic rst_b, // async reset, active low
  input wire logic chip_select, // select pin
  input wire logic serial_clock_in, // link clock
  input wire logic serial_data_in, // serial data in
  input wire logic width_select, // organization strap
  input wire logic data_out, // data out level
  input wire logic data_out_oe, // data out enable
  input wire logic prog_busy, // self-timed cycle running
  input wire logic write_enabled // write enable latch
);
  int busy_len; // length of the current busy spell

  // counts busy cycles
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      busy_len <= 0;
    end else if (prog_busy) begin
      busy_len <= busy_len + 1;
    end else begin
      busy_len <= 0;
    end
  end

  // select held low, and the end of a watched busy spell
  sequence sel_low_run;
    !chip_select [*4];
  endsequence
  sequence busy_ends;
    $fell(prog_busy) && $past(data_out_oe);
  endsequence

  oe_idle_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    sel_low_run |-> !data_out_oe) else $error("data out driven with select low");
  lock_gate_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    $rose(prog_busy) |-> write_enabled) else $error("programming while locked");
  start_fall_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    $rose(prog_busy) |-> !$past(chip_select, 2)) else $error("busy without select fall");
  lock_hold_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    $changed(write_enabled) |-> !$past(chip_select, 2)) else $error("latch moved in frame");
  busy_span_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    prog_busy |-> busy_len < PROG_CYCLES + 2) else $error("busy too long");
  busy_full_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    $fell(prog_busy) |-> busy_len >= PROG_CYCLES - 1) else $error("busy too short");
  busy_status_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    prog_busy && data_out_oe |-> !data_out) else $error("ready shown while busy");
  ready_status_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    busy_ends |-> ##[0:2] (data_out || !data_out_oe)) else $error("ready not shown");
  oe_sel_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    $rose(data_out_oe) |-> chip_select) else $error("data out enabled unselected");
  dummy_zero_a: assert property (@(posedge serial_clock_in) disable iff (!rst_b)
    $rose(data_out_oe) |-> !data_out) else $error("read dummy bit not zero");
endmodule : se3_core_asserts

bind se3_core se3_core_asserts #(.PROG_CYCLES(PROG_CYCLES)) i_asserts (
  .sys_clk(sys_clk), .rst_b(rst_b), .chip_select(chip_select),
  .serial_clock_in(serial_clock_in), .serial_data_in(serial_data_in),
  .width_select(width_select), .data_out(data_out), .data_out_oe(data_out_oe),
  .prog_busy(prog_busy), .write_enabled(write_enabled));

`default_nettype wire

//--- se3_host_model.sv
// host controller model driving the three-wire link of the eeprom core
// assumes a pull-up on the data out line; link clock runs only inside frames
`timescale 1ns/1ps
`default_nettype none

// ****************************************
// host model
// ****************************************
module se3_host_model
  import se3_pkg::*;
(
  output logic chip_select, // select to the device
  output logic serial_clock_in, // link clock, 12 ns period
  output logic serial_data_in, // serial data to the device
  input wire logic data_out, // device data level
  input wire logic data_out_oe // device drives data when high
);
  wire logic pin = data_out_oe ? data_out : 1'b1; // pulled up when released

  // idle levels
  initial begin
    chip_select = 1'b0;
    serial_clock_in = 1'b0;
    serial_data_in = 1'b0;
  end

  // one frame, msb first, then nrd more clocks, capturing the line from the last frame clock on
  task automatic frame(input logic [31:0] bits, input int n, input int nrd,
                       output logic [32:0] rd);
    rd = '0;
    chip_select <= 1'b1;
    #10;
    for (int j = 0; j < n + nrd; j++) begin
      serial_data_in <= (j < n) ? bits[n - 1 - j] : ~serial_data_in;
      #6 serial_clock_in <= 1'b1;
      #1 if (j >= n - 1) rd = {rd[31:0], pin};
      #5 serial_clock_in <= 1'b0;
      if (j == 4) #100; // clock held still mid-frame
    end
    #6 chip_select <= 1'b0;
    serial_data_in <= ~serial_data_in;
    #80;
  endtask : frame

  // raise select after the status wait and wait for ready
  task automatic poll(output logic busy0, output logic oe0, output logic rdy);
    #(STATUS_WAIT_TIME_NS);
    chip_select <= 1'b1;
    #300 busy0 = pin;
    oe0 = data_out_oe;
    rdy = 1'b0;
    for (int k = 0; k < 400 && !rdy; k++) #20 rdy = (pin === 1'b1);
    chip_select <= 1'b0;
    #80;
  endtask : poll
endmodule : se3_host_model

`default_nettype wire

//--- se3_core_tb.sv
// self-checking bench of the eeprom core with a host model on the link
// assumes a short programming count so each self-timed cycle is 40 clocks
`timescale 1ns/1ps
`default_nettype none

// ****************************************
// bench top
// ****************************************
module se3_core_tb
  import se3_pkg::*;
;
  localparam int PROG = 40;
  logic sys_clk = 1'b0;
  logic rst_b = 1'b0;
  logic width_select = 1'b0;
  wire logic chip_select, serial_clock_in, serial_data_in;
  wire logic data_out, data_out_oe, prog_busy, write_enabled;
  int n_errors = 0;
  int samples_checked = 0;
  logic [32:0] rd;
  logic b0, oe0, ok;

  always #10 sys_clk = ~sys_clk;

  se3_core #(.PROG_CYCLES(PROG)) i_dut (.sys_clk(sys_clk), .rst_b(rst_b),
    .chip_select(chip_select), .serial_clock_in(serial_clock_in),
    .serial_data_in(serial_data_in), .width_select(width_select), .data_out(data_out),
    .data_out_oe(data_out_oe), .prog_busy(prog_busy), .write_enabled(write_enabled));
  se3_host_model i_host (.chip_select(chip_select), .serial_clock_in(serial_clock_in),
    .serial_data_in(serial_data_in), .data_out(data_out), .data_out_oe(data_out_oe));

  // compare and count
  task automatic chk(input string what, input logic [32:0] seen, input logic [32:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  // build start, opcode, address and data, then run the frame
  task automatic send(input logic [1:0] op, input logic [8:0] a, input logic [15:0] d,
                      input int nd, input int nrd);
    int na;
    logic [31:0] v;
    na = width_select ? 8 : 9;
    v = 32'h1;
    v = (v << 2) | 32'(op);
    v = (v << na) | 32'(a);
    v = (v << nd) | 32'(d);
    i_host.frame(v, 3 + na + nd, nrd, rd);
  endtask : send

  // special instruction, sub-code in the two top address bits
  task automatic spec(input logic [1:0] sub, input logic [15:0] d, input int nd);
    send(OP_SPECIAL, width_select ? {1'b0, sub, 6'h0} : {sub, 7'h0}, d, nd, 0);
  endtask : spec

  task automatic t_reset();
    chk("latch", write_enabled, 1'b0);
    chk("oe", data_out_oe, 1'b0);
    chk("busy", prog_busy, 1'b0);
  endtask : t_reset

  task automatic t_locked();
    send(OP_WRITE, 9'h005, 16'h3c, 8, 0);
    #100 chk("busy", prog_busy, 1'b0);
    send(OP_READ, 9'h005, 16'h0, 0, 8);
    chk("rd5", rd[8:0], 9'h0ff);
  endtask : t_locked

  task automatic t_write();
    spec(WRITE_ENABLE_INSTR, 16'h0, 0);
    chk("latch", write_enabled, 1'b1);
    send(OP_WRITE, 9'h0ff, 16'h5a, 8, 0);
    i_host.poll(b0, oe0, ok);
    chk("status", {oe0, b0, ok}, 3'b101);
    send(OP_WRITE, 9'h0ff, 16'ha5, 8, 0);
    i_host.poll(b0, oe0, ok);
    chk("ready", ok, 1'b1);
    send(OP_READ, 9'h0ff, 16'h0, 0, 16);
    chk("rdwrap", rd[16:0], {1'b0, 8'ha5, 8'hff});
    send(OP_READ, 9'h0fe, 16'h0, 0, 8);
    chk("rdnext", rd[8:0], 9'h0ff);
  endtask : t_write

  task automatic t_count();
    send(OP_SPECIAL, {PROGRAM_LOCK_INSTR, 7'h0}, 16'h1, 1, 0);
    chk("latch", write_enabled, 1'b1);
    send(OP_ERASE, 9'h0ff, 16'h0, 0, 0);
    i_host.poll(b0, oe0, ok);
    chk("status", {oe0, b0, ok}, 3'b101);
    send(OP_READ, 9'h0ff, 16'h0, 0, 8);
    chk("rderase", rd[8:0], 9'h0ff);
  endtask : t_count

  task automatic t_late();
    send(OP_WRITE, 9'h001, 16'h11, 8, 0);
    #((PROG + 20) * 20);
    i_host.poll(b0, oe0, ok);
    chk("nostatus", oe0, 1'b0);
    send(OP_READ, 9'h001, 16'h0, 0, 8);
    chk("rd1", rd[8:0], 9'h011);
  endtask : t_late

  task automatic t_word();
    @(posedge sys_clk) width_select <= 1'b1;
    #100 spec(FILL_ARRAY_INSTR, 16'h1234, 16);
    i_host.poll(b0, oe0, ok);
    chk("status", {oe0, b0, ok}, 3'b101);
    send(OP_READ, 9'h07f, 16'h0, 0, 32);
    chk("rdword", rd, {1'b0, 16'h1234, 16'h1234});
    @(posedge sys_clk) width_select <= 1'b0;
    #100 send(OP_READ, 9'h000, 16'h0, 0, 8);
    chk("rdhigh", rd[8:0], 9'h012);
    @(posedge sys_clk) width_select <= 1'b1;
    #100 spec(CLEAR_ARRAY_INSTR, 16'h0, 0);
    i_host.poll(b0, oe0, ok);
    send(OP_READ, 9'h000, 16'h0, 0, 16);
    chk("rdclear", rd[16:0], 17'h0ffff);
    spec(PROGRAM_LOCK_INSTR, 16'h0, 0);
    chk("latch", write_enabled, 1'b0);
    send(OP_WRITE, 9'h000, 16'h0, 16, 0);
    #100 chk("busy", prog_busy, 1'b0);
  endtask : t_word

  // counts and verdict
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : wrap_up

  // main sequence
  initial begin
    repeat (10) @(posedge sys_clk);
    rst_b <= 1'b1;
    repeat (5) @(posedge sys_clk);
    t_reset();
    t_locked();
    t_write();
    t_count();
    t_late();
    t_word();
    wrap_up();
  end

  // watchdog
  initial begin
    #1000000;
    n_errors++;
    wrap_up();
  end
endmodule : se3_core_tb

`default_nettype wire
